//--- xor_dir_consts.svh
// Constants for the exclusive-OR and direction-load execution unit
`ifndef XOR_DIR_CONSTS_SVH
`define XOR_DIR_CONSTS_SVH
// Opcode fields of the 14-bit instruction word
`define LIT_XOR_OPC      6'h3A
`define FILE_XOR_OPC     4'h6
`define DIR_LOAD_OPC     11'h00C
`define DIR_SEL_FIRST    3'h5
`define DIR_SEL_LAST     3'h7
// File addresses that alias the direction registers
`define DIR_FILE_ADDR0   7'h05
`define DIR_FILE_ADDR1   7'h06
`define DIR_FILE_ADDR2   7'h07
// Reset values
`define ACC_RESET        8'h00
`define DIR_RESET        8'hFF
`endif

//--- xor_dir_pkg.sv
// Types for the exclusive-OR and direction-load execution unit
package xor_dir_pkg;
	// Decoded operation classes
	typedef enum logic [1:0] {
		OP_NONE,
		OP_LIT_XOR,
		OP_FILE_XOR,
		OP_DIR_LOAD
	} op_type;
endpackage : xor_dir_pkg

//--- xor_dir_exec.sv
// Decode and execute literal XOR, file XOR and direction-register load
`timescale 1ns/1ps
`include "xor_dir_consts.svh"
module xor_dir_exec #(
	parameter int DATA_W = 8
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              resetn_i,
	// Instruction issue, one per cycle when valid
	input  wire logic              instr_valid_i,
	input  wire logic [13:0]       instr_i,
	// File-register read data for the addressed register (combinational)
	input  wire logic [DATA_W-1:0] file_rdata_i,
	// Ordinary file writes from the rest of the core
	input  wire logic              core_wr_i,
	input  wire logic [6:0]        core_waddr_i,
	input  wire logic [DATA_W-1:0] core_wdata_i,
	// File-register write port driven by this unit
	output logic                   file_we_o,
	output logic [6:0]             file_waddr_o,
	output logic [DATA_W-1:0]      file_wdata_o,
	// Architectural state
	output logic [DATA_W-1:0]      acc_o,
	output logic                   zero_o,
	output logic [DATA_W-1:0]      dir0_o,
	output logic [DATA_W-1:0]      dir1_o,
	output logic [DATA_W-1:0]      dir2_o
);
	import xor_dir_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State
	logic [DATA_W-1:0] acc_q, acc_d;         // Accumulator
	logic              zero_q, zero_d;       // Zero status flag
	logic [DATA_W-1:0] dir_q [3];            // Direction registers
	logic [DATA_W-1:0] dir_d [3];            // Direction registers, next value
	logic              we_q, we_d;           // File write strobe
	logic [6:0]        waddr_q, waddr_d;     // File write address, held after the pulse
	logic [DATA_W-1:0] wdata_q, wdata_d;     // File write data, held after the pulse
	op_type            op;                   // Decoded class
	logic [DATA_W-1:0] result;               // XOR result

	// The direction file lives here, not in the core's register file, so the
	// core must return dir0_o..dir2_o on file_rdata_i for the aliased addresses.
	// Keeping one copy lets the dedicated load and plain file writes agree.
	// Map a file address onto a direction index, valid flag in top bit
	function automatic logic [2:0] dir_index(input logic [6:0] a);
		case (a)
			`DIR_FILE_ADDR0: dir_index = 3'b100;
			`DIR_FILE_ADDR1: dir_index = 3'b101;
			`DIR_FILE_ADDR2: dir_index = 3'b110;
			default:         dir_index = 3'b000;
		endcase
	endfunction : dir_index

	////////////////////////////////////////////////////////////////////////
	// Decode
	// Classify the issued word; anything unmatched is ignored
	// Direction selectors below five fall through to no operation
	always_comb begin
		op = OP_NONE;
		if (instr_valid_i) begin
			if (instr_i[13:8] == `LIT_XOR_OPC)
				op = OP_LIT_XOR;
			else if (instr_i[13:12] == 2'h0 && instr_i[11:8] == `FILE_XOR_OPC)
				op = OP_FILE_XOR;
			else if (instr_i[13:3] == `DIR_LOAD_OPC && instr_i[2:0] >= `DIR_SEL_FIRST)
				op = OP_DIR_LOAD;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state computation
	// Default is hold; the write strobe falls back to zero every cycle,
	// so a file write never lasts longer than one clock
	always_comb begin
		logic [2:0] di;
		di = 3'b000;
		acc_d   = acc_q;
		zero_d  = zero_q;
		dir_d   = dir_q;
		we_d    = 1'b0;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		result  = acc_q ^ ((op == OP_LIT_XOR) ? instr_i[7:0] : file_rdata_i);
		// Core writes to the aliased addresses land in the direction file
		if (core_wr_i) begin
			di = dir_index(core_waddr_i);
			if (di[2])
				dir_d[di[1:0]] = core_wdata_i;
		end
		// Instruction effects come last, so they win over a same-cycle core write
		case (op)
			OP_LIT_XOR: begin
				acc_d  = result;
				zero_d = (result == '0);
			end
			OP_FILE_XOR: begin
				zero_d = (result == '0);
				if (instr_i[7]) begin
					we_d    = 1'b1;
					waddr_d = instr_i[6:0];
					wdata_d = result;
					di = dir_index(instr_i[6:0]);
					if (di[2])
						dir_d[di[1:0]] = result;
				end else begin
					acc_d = result;
				end
			end
			OP_DIR_LOAD: begin
				// Index 5..7 maps to 0..2; status left alone
				dir_d[2'(instr_i[2:0] - `DIR_SEL_FIRST)] = acc_q;
			end
			default: ;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	// Asynchronous reset loads constants only
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			acc_q   <= `ACC_RESET;
			zero_q  <= 1'b0;
			for (int i = 0; i < 3; i++) dir_q[i] <= `DIR_RESET;
			we_q    <= 1'b0;
			waddr_q <= 7'h00;
			wdata_q <= '0;
		end else begin
			acc_q   <= acc_d;
			zero_q  <= zero_d;
			dir_q   <= dir_d;
			we_q    <= we_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
		end
	end

	// Outputs straight from flops
	assign acc_o        = acc_q;
	assign zero_o       = zero_q;
	assign dir0_o       = dir_q[0];
	assign dir1_o       = dir_q[1];
	assign dir2_o       = dir_q[2];
	assign file_we_o    = we_q;
	assign file_waddr_o = waddr_q;
	assign file_wdata_o = wdata_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	// Properties run on the core clock and are silenced while reset is low.
	// Each looks one edge after the issue cycle, where the flops have moved.

	// Register-destination file XOR issue cycle
	sequence s_file_to_reg;
		op == OP_FILE_XOR && instr_i[7];
	endsequence
	chk_file_wdata_value: assert property (@(posedge clk_i) disable iff (!resetn_i)
		s_file_to_reg |=> wdata_q == ($past(acc_q) ^ $past(file_rdata_i)))
		else $error("file xor write data wrong");
	// Register-destination XOR onto an aliased address updates the direction file
	chk_dir_alias_xor: assert property (@(posedge clk_i) disable iff (!resetn_i)
		s_file_to_reg ##0 instr_i[6:0] == `DIR_FILE_ADDR1
		|=> dir1_o == ($past(acc_q) ^ $past(file_rdata_i)))
		else $error("aliased direction write lost");
	// Accumulator-destination file XOR leaves the direction file alone
	chk_file_acc_dirs: assert property (@(posedge clk_i) disable iff (!resetn_i)
		op == OP_FILE_XOR && !instr_i[7] && !core_wr_i |=> $stable(dir0_o) && $stable(dir1_o) && $stable(dir2_o))
		else $error("file xor to accumulator touched direction file");
	// Refused direction selectors
	sequence s_dir_refused;
		instr_valid_i && instr_i[13:3] == `DIR_LOAD_OPC && instr_i[2:0] < `DIR_SEL_FIRST && !core_wr_i;
	endsequence
	chk_dir_sel_refused: assert property (@(posedge clk_i) disable iff (!resetn_i)
		s_dir_refused |=> $stable(dir0_o) && $stable(dir1_o) && $stable(dir2_o) && $stable(acc_q))
		else $error("refused direction selector changed state");
	// Direction load issue cycle
	sequence s_dir_load;
		op == OP_DIR_LOAD;
	endsequence
	chk_dir_load_acc: assert property (@(posedge clk_i) disable iff (!resetn_i)
		s_dir_load |=> $stable(acc_q) && !we_q)
		else $error("direction load disturbed accumulator or write port");
	// Selector five lands in the first direction register
	chk_dir_load_first: assert property (@(posedge clk_i) disable iff (!resetn_i)
		s_dir_load ##0 instr_i[2:0] == `DIR_SEL_FIRST |=> dir0_o == $past(acc_q))
		else $error("direction load to first register wrong");
	// The instruction wins when a core write hits the same direction register
	chk_dir_load_wins: assert property (@(posedge clk_i) disable iff (!resetn_i)
		s_dir_load ##0 (instr_i[2:0] == 3'h6 && core_wr_i && core_waddr_i == `DIR_FILE_ADDR1)
		|=> dir1_o == $past(acc_q))
		else $error("core write overrode direction load");
	// Literal XOR leaves the direction file and the write port alone
	chk_lit_keeps_dirs: assert property (@(posedge clk_i) disable iff (!resetn_i)
		op == OP_LIT_XOR && !core_wr_i |=> $stable(dir0_o) && $stable(dir1_o) && $stable(dir2_o) && !we_q)
		else $error("literal xor touched direction file");

	// Literal XOR issue cycle
	sequence s_lit_issue;
		instr_valid_i && instr_i[13:8] == `LIT_XOR_OPC;
	endsequence
	chk_lit_acc_result: assert property (@(posedge clk_i) disable iff (!resetn_i)
		s_lit_issue |=> acc_q == ($past(acc_q) ^ $past(instr_i[7:0])))
		else $error("literal xor result wrong");
	chk_file_acc_dest: assert property (@(posedge clk_i) disable iff (!resetn_i)
		op == OP_FILE_XOR && !instr_i[7] |=> acc_q == ($past(acc_q) ^ $past(file_rdata_i)) && !we_q)
		else $error("file xor to accumulator wrong");
	chk_file_reg_dest: assert property (@(posedge clk_i) disable iff (!resetn_i)
		op == OP_FILE_XOR && instr_i[7] |=> we_q && acc_q == $past(acc_q) && waddr_q == $past(instr_i[6:0]))
		else $error("file xor to register wrong");
	chk_dir_load_copy: assert property (@(posedge clk_i) disable iff (!resetn_i)
		op == OP_DIR_LOAD && instr_i[2:0] == 3'h7 && !core_wr_i |=> dir2_o == $past(acc_q) && $stable(zero_q))
		else $error("direction load wrong");
	chk_dir_file_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
		core_wr_i && core_waddr_i == `DIR_FILE_ADDR0 && op == OP_NONE |=> dir0_o == $past(core_wdata_i))
		else $error("direct direction write lost");
	chk_zero_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(op == OP_LIT_XOR || op == OP_FILE_XOR) |=> zero_q == (wdata_q == 8'h00 && we_q || acc_q == 8'h00 && !we_q))
		else $error("zero flag wrong");
	chk_zero_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
		op == OP_NONE || op == OP_DIR_LOAD |=> $stable(zero_q))
		else $error("zero flag changed unexpectedly");
	chk_we_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i)
		op != OP_FILE_XOR |=> !we_q)
		else $error("spurious file write");
endmodule : xor_dir_exec

//--- xor_and_direction_load_exec_tb.sv
// Self-checking bench for the XOR and direction-load execution unit
`timescale 1ns/1ps
`include "xor_dir_consts.svh"
module xor_and_direction_load_exec_tb;
	logic        clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        instr_valid_i = 1'b0;
	logic [13:0] instr_i = 14'h0000;
	logic [7:0]  file_rdata_i = 8'h00;
	logic        core_wr_i = 1'b0;
	logic [6:0]  core_waddr_i = 7'h00;
	logic [7:0]  core_wdata_i = 8'h00;
	logic        file_we_o, zero_o, taken_q = 1'b0;
	logic [6:0]  file_waddr_o;
	logic [7:0]  file_wdata_o, acc_o, dir0_o, dir1_o, dir2_o;
	logic [7:0]  m_acc = 8'h00, m_wd = 8'h00, m_dir [3] = '{8'hFF, 8'hFF, 8'hFF};
	logic [6:0]  m_wa = 7'h00;
	logic        m_z = 1'b0, m_we;
	logic [48:0] exp_q [$];
	logic [48:0] e;
	logic [15:0] rnd = 16'h92D2;
	logic [13:0] ins;
	int          error_cnt = 0, check_count = 0, cyc = 0;

	always #5 clk_i = ~clk_i;

	xor_dir_exec #(.DATA_W(8)) u_xor_dir_exec (.clk_i(clk_i), .resetn_i(resetn_i),
		.instr_valid_i(instr_valid_i), .instr_i(instr_i), .file_rdata_i(file_rdata_i),
		.core_wr_i(core_wr_i), .core_waddr_i(core_waddr_i), .core_wdata_i(core_wdata_i),
		.file_we_o(file_we_o), .file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o),
		.acc_o(acc_o), .zero_o(zero_o), .dir0_o(dir0_o), .dir1_o(dir1_o), .dir2_o(dir2_o));

	function automatic logic [15:0] lfsr_next(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr_next

	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////////////
	// Model one issue cycle, note the expected state, then drive the ports
	task automatic step(input logic [13:0] i, input logic [7:0] rd, input logic cw, input logic [6:0] ca,
			input logic [7:0] cd);
		logic [7:0] r;
		r = m_acc ^ ((i[13:8] == `LIT_XOR_OPC) ? i[7:0] : rd);
		m_we = 1'b0;
		if (cw && ca >= `DIR_FILE_ADDR0 && ca <= `DIR_FILE_ADDR2) m_dir[ca - 7'h05] = cd;
		if (i[13:8] == `LIT_XOR_OPC) begin
			m_acc = r;
			m_z = (r == 8'h00);
		end else if (i[13:8] == {2'b00, `FILE_XOR_OPC}) begin
			m_z = (r == 8'h00);
			if (i[7]) begin
				{m_we, m_wa, m_wd} = {1'b1, i[6:0], r};
				if (i[6:0] >= `DIR_FILE_ADDR0 && i[6:0] <= `DIR_FILE_ADDR2) m_dir[i[6:0] - 7'h05] = r;
			end else m_acc = r;
		end else if (i[13:3] == `DIR_LOAD_OPC && i[2:0] >= `DIR_SEL_FIRST) m_dir[i[2:0] - 3'h5] = m_acc;
		exp_q.push_back({m_we, m_wa, m_wd, m_acc, m_z, m_dir[0], m_dir[1], m_dir[2]});
		@(posedge clk_i);
		{instr_valid_i, instr_i, file_rdata_i} <= {1'b1, i, rd};
		{core_wr_i, core_waddr_i, core_wdata_i} <= {cw, ca, cd};
	endtask : step

	// Results show at the taking edge itself; compare at the falling edge that follows it
	always @(posedge clk_i) taken_q <= resetn_i && instr_valid_i;
	always @(negedge clk_i) begin
		if (taken_q && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			chk("acc", {16'h0000, acc_o}, {16'h0000, e[32:25]});
			chk("zero", {23'h0, zero_o}, {23'h0, e[24]});
			chk("write", {8'h00, file_we_o, file_waddr_o, file_wdata_o}, {8'h00, e[48:33]});
			chk("dirs", {dir0_o, dir1_o, dir2_o}, e[23:0]);
		end
	end

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			wrap_up();
		end
	end

	initial begin
		repeat (8) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(negedge clk_i);
		chk("dir reset", {dir0_o, dir1_o, dir2_o}, {3{`DIR_RESET}});
		chk("acc reset", {16'h0000, acc_o}, {16'h0000, `ACC_RESET});
		chk("zero reset", {23'h0, zero_o}, {23'h0, 1'b0});
		chk("write reset", {8'h00, file_we_o, file_waddr_o, file_wdata_o}, 24'h000000);
		// Every selector, out-of-range ones must be ignored
		for (int s = 0; s < 8; s++) begin
			step({`LIT_XOR_OPC, 5'h0, s[2:0]}, 8'h00, 1'b0, 7'h00, 8'h00);
			step({`DIR_LOAD_OPC, s[2:0]}, 8'h00, 1'b0, 7'h00, 8'h00);
		end
		$display("test direction sweep done");
		// Random back-to-back mix with concurrent core writes
		for (int n = 0; n < 300; n++) begin
			rnd = lfsr_next(rnd);
			case (rnd[1:0])
				2'd0: ins = {`LIT_XOR_OPC, rnd[3] ? m_acc : rnd[15:8]};
				2'd1: ins = {2'b00, `FILE_XOR_OPC, rnd[2], rnd[4] ? {4'h0, rnd[14:12]} : rnd[14:8]};
				2'd2: ins = {`DIR_LOAD_OPC, rnd[4:2]};
				default: ins = {6'h3F, rnd[15:8]};
			endcase
			step(ins, rnd[3] ? m_acc : rnd[15:8], rnd[5], {4'h0, rnd[8:6]}, rnd[15:8]);
		end
		@(posedge clk_i);
		{instr_valid_i, core_wr_i} <= 2'b00;
		repeat (3) @(posedge clk_i);
		$display("test random mix done");
		wrap_up();
	end
endmodule : xor_and_direction_load_exec_tb
